/* File: design/host_event_mask_and_app_tag.sv */
`timescale 1ns/1ps
`default_nettype none
module host_event_mask_and_app_tag
  import event_tag_pkg::*;
(
  input  wire logic              ref_clk,
  input  wire logic              reset_n,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [DATA_W-1:0] wr_data,
  input  wire logic              wr_stb,
  input  wire logic              rd_stb,
  output logic      [DATA_W-1:0] rd_data,
  input  wire logic [7:0]        event_set,
  output logic                   host_event_irq
);

  ////////////////////////////////////////////////////////////////////////
  // State

  state_type st_r;
  state_type st_nxt;
  logic [7:0] free_tag;
  logic       wr_event;
  logic       wr_enable;
  logic       wr_owner;
  logic       wr_alloc;
  logic       wr_clear;
  logic       rd_alloc;
  logic [TAG_N-1:0] lower_free;
  logic [7:0]       scan_idx [TAG_N];

  // Ripple scan for the lowest free tag. Entry zero never takes part, so an
  // exhausted pool reads as zero. The chain is long but only a row of muxes,
  // and the allocator is read too rarely for its delay to matter.
  assign lower_free[0] = 1'b0;
  assign scan_idx[0]   = NO_TAG;

  for (genvar i = 1; i < TAG_N; i++) begin : g_tag_scan
    assign lower_free[i] = lower_free[i-1] | !st_r.used[i];
    assign scan_idx[i]   = (!st_r.used[i] && !lower_free[i-1])
                           ? 8'(i) : scan_idx[i-1];
  end

  assign free_tag  = lower_free[TAG_N-1] ? scan_idx[TAG_N-1] : NO_TAG;
  assign wr_event  = wr_stb && (addr == OFS_EVENT_HIGH);
  assign wr_enable = wr_stb && (addr == OFS_ENABLE_HIGH);
  assign wr_owner  = wr_stb && (addr == OFS_OWNER_TAG);
  assign wr_alloc  = wr_stb && (addr == OFS_TAG_ALLOC);
  assign wr_clear  = wr_stb && (addr == OFS_CLEAR_EN);
  assign rd_alloc  = rd_stb && (addr == OFS_TAG_ALLOC);

  ////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    st_nxt = st_r;

    if (wr_enable) begin
      st_nxt.enable = wr_data;
    end

    if (wr_clear) begin
      st_nxt.clear_en = wr_data;
    end

    // Host clear first so that a same-cycle set from the controller wins
    if (wr_event) begin
      st_nxt.events = st_r.events & ~(wr_data & st_r.clear_en);
    end
    st_nxt.events = st_nxt.events | event_set;

    // A held tag yields only to its own value; any other write bounces off
    if (wr_owner) begin
      if (st_r.owner == NO_TAG) begin
        st_nxt.owner = wr_data;
      end else if (wr_data == st_r.owner) begin
        st_nxt.owner = NO_TAG;
      end else begin
        st_nxt.owner = st_r.owner;
      end
    end

    // Writing a tag number to the allocator hands that tag back
    // Nothing checks who took the tag: any master may return one
    if (wr_alloc && (wr_data != NO_TAG)) begin
      st_nxt.used[wr_data] = 1'b0;
    end

    // Read data fall back to zero outside the answering cycle
    st_nxt.rd_data = READ_ZERO;
    if (rd_stb) begin
      if (addr == OFS_EVENT_HIGH) begin
        st_nxt.rd_data = st_r.events;
      end else if (addr == OFS_ENABLE_HIGH) begin
        st_nxt.rd_data = st_r.enable;
      end else if (addr == OFS_OWNER_TAG) begin
        st_nxt.rd_data = st_r.owner;
      end else if (addr == OFS_CLEAR_EN) begin
        st_nxt.rd_data = st_r.clear_en;
      end else if (addr == OFS_TAG_ALLOC) begin
        st_nxt.rd_data = free_tag;
        if (free_tag != NO_TAG) begin
          st_nxt.used[free_tag] = 1'b1;
        end
      end
    end
    // Entry zero stays pinned as taken so the scan can never offer it
    st_nxt.used[0] = 1'b1;
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_r.enable   <= RST_ENABLE;
      st_r.events   <= RST_EVENT;
      st_r.clear_en <= RST_CLEAR_EN;
      st_r.owner    <= RST_OWNER;
      st_r.used     <= {{(TAG_N-1){1'b0}}, 1'b1};
      st_r.rd_data  <= READ_ZERO;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rd_data        = st_r.rd_data;
  assign host_event_irq = |(st_r.events & st_r.enable);

  ////////////////////////////////////////////////////////////////////////
  // Checks
  // All of them sleep through reset; the first sample is the edge after release

  enable_write_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    wr_enable |=> st_r.enable == $past(wr_data))
    else $error("enable register did not take written value");

  irq_rise_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    $rose(host_event_irq) |-> $past(wr_enable) || $past(|event_set))
    else $error("interrupt rose with no enable write or event");

  irq_gate_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (|event_set && !wr_enable && (|(event_set & st_r.enable)))
      |=> host_event_irq)
    else $error("enabled event did not raise interrupt");

  irq_block_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    wr_enable && wr_data == 8'h00 && !(|event_set) |=> !host_event_irq)
    else $error("interrupt stayed high with all enables clear");

  owner_claim_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    wr_owner && st_r.owner == NO_TAG |=> st_r.owner == $past(wr_data))
    else $error("free owner tag did not take written value");

  owner_release_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    wr_owner && st_r.owner != NO_TAG && wr_data == st_r.owner
      |=> st_r.owner == NO_TAG)
    else $error("matching write did not release owner tag");

  owner_keep_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    wr_owner && st_r.owner != NO_TAG && wr_data != st_r.owner
      |=> $stable(st_r.owner))
    else $error("mismatching write changed held owner tag");

  alloc_give_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    rd_alloc && free_tag != NO_TAG
      |=> rd_data == $past(free_tag) && st_r.used[rd_data])
    else $error("allocator read did not return and reserve tag");

  alloc_zero_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    rd_alloc && (&st_r.used) |=> rd_data == NO_TAG)
    else $error("allocator returned a tag while none free");

  tag_zero_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    rd_alloc && !(&st_r.used) |=> rd_data != NO_TAG && st_r.used[0])
    else $error("tag zero offered as free");

  event_set_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    |event_set |=> (st_r.events & $past(event_set)) == $past(event_set))
    else $error("controller event lost");

  event_clear_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    wr_event && !(|event_set)
      |=> st_r.events == ($past(st_r.events) & ~($past(wr_data) & $past(st_r.clear_en))))
    else $error("host clear of events wrong");

  ////////////////////////////////////////////////////////////////////////
  // Checks on register writes, holding and read-back

  // The enable, owner and clear enable registers may move only under their own write strobes
  enable_hold_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    !wr_enable |=> $stable(st_r.enable))
    else $error("enable register changed without a write");

  enable_read_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    rd_stb && addr == OFS_ENABLE_HIGH |=> rd_data == $past(st_r.enable))
    else $error("enable register read back wrong");

  owner_hold_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    !wr_owner |=> $stable(st_r.owner))
    else $error("owner tag changed without a write");

  owner_read_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    rd_stb && addr == OFS_OWNER_TAG |=> rd_data == $past(st_r.owner))
    else $error("owner tag read back wrong");

  event_read_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    rd_stb && addr == OFS_EVENT_HIGH |=> rd_data == $past(st_r.events))
    else $error("event register read back wrong");

  clear_write_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    wr_clear |=> st_r.clear_en == $past(wr_data))
    else $error("clear enable did not take written value");

  clear_hold_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    !wr_clear |=> $stable(st_r.clear_en))
    else $error("clear enable changed without a write");

  clear_read_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    rd_stb && addr == OFS_CLEAR_EN |=> rd_data == $past(st_r.clear_en))
    else $error("clear enable read back wrong");

  // Read data stand for one cycle only, so a stale value never looks fresh
  rd_idle_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    !rd_stb |=> rd_data == READ_ZERO)
    else $error("read data not zero outside a read");

  rd_unmapped_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    rd_stb && addr != OFS_EVENT_HIGH && addr != OFS_ENABLE_HIGH
      && addr != OFS_OWNER_TAG && addr != OFS_CLEAR_EN && addr != OFS_TAG_ALLOC
      |=> rd_data == READ_ZERO)
    else $error("unmapped read returned data");

  ////////////////////////////////////////////////////////////////////////
  // Checks on events and interrupt

  // Protected bits must survive a host clear untouched
  event_guard_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    wr_event |=> (st_r.events & ~$past(st_r.clear_en))
      == (($past(st_r.events) | $past(event_set)) & ~$past(st_r.clear_en)))
    else $error("protected event bit cleared by host");

  event_hold_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    !wr_event && !(|event_set) |=> $stable(st_r.events))
    else $error("events changed with no set or clear");

  // Enabling a bit that is already pending must raise the line at once
  irq_enable_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    wr_enable && (|(st_r.events & wr_data)) |=> host_event_irq)
    else $error("enabling a pending event gave no interrupt");

  irq_off_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    wr_enable && !(|(st_r.events & wr_data)) && !(|(event_set & wr_data))
      |=> !host_event_irq)
    else $error("interrupt high with no enabled event");

  irq_hold_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    host_event_irq && !wr_enable && !wr_event |=> host_event_irq)
    else $error("interrupt dropped with events still enabled");

  irq_clear_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    wr_event && (|(st_r.events & st_r.enable & ~(wr_data & st_r.clear_en)))
      |=> host_event_irq)
    else $error("interrupt dropped while an enabled event remained");

  irq_drop_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    $fell(host_event_irq) |-> $past(wr_enable) || $past(wr_event))
    else $error("interrupt fell with no enable write or clear");

  ////////////////////////////////////////////////////////////////////////
  // Checks on the tag pool

  used_zero_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    st_r.used[0])
    else $error("tag zero left the reserved set");

  alloc_pick_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    free_tag != NO_TAG |-> !st_r.used[free_tag])
    else $error("offered tag is already in use");

  alloc_empty_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    free_tag == NO_TAG |-> &st_r.used)
    else $error("pool reported empty with a tag free");

  // A read takes exactly one tag, so a later read cannot see it again until it is handed back
  alloc_count_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    rd_alloc && free_tag != NO_TAG
      |=> $countones(st_r.used) == $countones($past(st_r.used)) + 1)
    else $error("allocator read did not reserve exactly one tag");

  used_hold_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    !rd_alloc && !wr_alloc |=> $stable(st_r.used))
    else $error("tag pool changed with no allocator access");

  // Handing a tag back is how firmware recycles it; zero is not a tag
  alloc_free_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    wr_alloc && wr_data != NO_TAG |=> !st_r.used[$past(wr_data)])
    else $error("returned tag not freed");

  alloc_keep_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    wr_alloc && wr_data == NO_TAG |=> $stable(st_r.used))
    else $error("writing zero to allocator changed the pool");

  alloc_read_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    rd_alloc |=> rd_data == $past(free_tag))
    else $error("allocator read returned wrong tag");

  alloc_none_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    rd_alloc && free_tag == NO_TAG |=> $stable(st_r.used))
    else $error("read of an empty pool changed it");

endmodule
`default_nettype wire

/* File: include/event_tag_pkg.sv */
// Notes on behaviour
// - Set enable bit passes its event to interrupt
// - Enable register at 0Bh, read/write, resets zero
// - Empty owner tag accepts any written value
// - Writing the held tag releases it to zero
// - Other writes to a held tag are ignored
// - Allocator read returns and reserves next free tag
// - Zero never handed out; zero means none free
// - Controller sets events; host clears by writing one where the clear enable bit is set
package event_tag_pkg;

  localparam int          ADDR_W          = 8;
  localparam int          DATA_W          = 8;
  localparam int          TAG_N           = 256;

  localparam logic [7:0]  OFS_EVENT_HIGH  = 8'h09;
  localparam logic [7:0]  OFS_ENABLE_HIGH = 8'h0b;
  localparam logic [7:0]  OFS_OWNER_TAG   = 8'h0c;
  localparam logic [7:0]  OFS_TAG_ALLOC   = 8'h10;
  localparam logic [7:0]  OFS_CLEAR_EN    = 8'h16;

  localparam logic [7:0]  RST_ENABLE      = 8'h00;
  localparam logic [7:0]  RST_EVENT       = 8'h00;
  localparam logic [7:0]  RST_OWNER       = 8'h00;
  localparam logic [7:0]  RST_CLEAR_EN    = 8'hff;
  localparam logic [7:0]  NO_TAG          = 8'h00;
  localparam logic [7:0]  READ_ZERO       = 8'h00;

  typedef struct packed {
    logic [7:0]       enable;
    logic [7:0]       events;
    logic [7:0]       clear_en;
    logic [7:0]       owner;
    logic [TAG_N-1:0] used;
    logic [7:0]       rd_data;
  } state_type;

endpackage

/* File: testbench/event_source.sv */
`timescale 1ns/1ps
`default_nettype none
module event_source (
  input  wire logic       ref_clk,
  input  wire logic       reset_n,
  input  wire logic       fire,
  input  wire logic [7:0] bits,
  output logic      [7:0] event_set
);
  // One-cycle pulse only, so the device has to latch the event itself
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      event_set <= 8'h00;
    end else begin
      event_set <= fire ? bits : 8'h00;
    end
  end
endmodule
`default_nettype wire

/* File: testbench/test_host_event_mask_and_app_tag.sv */
`timescale 1ns/1ps
`default_nettype none
module test_host_event_mask_and_app_tag;
  import event_tag_pkg::*;
  logic       ref_clk = 0, reset_n = 0, wr_stb = 0, rd_stb = 0, fire = 0;
  logic [7:0] addr = 8'h00, wr_data = 8'h00, bits = 8'h00, rd_data, event_set;
  logic       host_event_irq;
  int         mismatches = 0, checked = 0;
  initial begin
    forever #4 ref_clk = ~ref_clk;
  end
  host_event_mask_and_app_tag DUT (.ref_clk(ref_clk), .reset_n(reset_n), .addr(addr),
    .wr_data(wr_data), .wr_stb(wr_stb), .rd_stb(rd_stb), .rd_data(rd_data),
    .event_set(event_set), .host_event_irq(host_event_irq));
  event_source far (.ref_clk(ref_clk), .reset_n(reset_n), .fire(fire), .bits(bits),
    .event_set(event_set));
  ////////////////////////////////////////////////////////////////
  task automatic chk(string n, logic [7:0] e, logic [7:0] g);
    checked++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge ref_clk) begin wr_stb <= 1; addr <= a; wr_data <= d; end
    @(posedge ref_clk) wr_stb <= 0;
  endtask
  task automatic rd(logic [7:0] a, logic [7:0] e);
    @(posedge ref_clk) begin rd_stb <= 1; addr <= a; end
    @(posedge ref_clk) rd_stb <= 0;
    #1 chk("rd_data", e, rd_data);
    @(posedge ref_clk);
    #1 chk("rd_idle", READ_ZERO, rd_data);
  endtask
  task automatic raise(logic [7:0] b, logic e);
    @(posedge ref_clk) begin fire <= 1; bits <= b; end
    @(posedge ref_clk) fire <= 0;
    repeat (2) @(posedge ref_clk);
    #1 chk("irq", {7'h0, e}, {7'h0, host_event_irq});
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic reset_values;
    rd(OFS_ENABLE_HIGH, 8'h00);
    rd(OFS_OWNER_TAG, 8'h00);
    rd(OFS_EVENT_HIGH, RST_EVENT);
    rd(OFS_CLEAR_EN, RST_CLEAR_EN);
    rd(8'h20, READ_ZERO);
  endtask
  task automatic mask_and_irq;
    wr(OFS_ENABLE_HIGH, 8'h80);
    rd(OFS_ENABLE_HIGH, 8'h80);
    raise(8'h01, 1'b0);
    rd(OFS_EVENT_HIGH, 8'h01);
    raise(8'h80, 1'b1);
    wr(OFS_EVENT_HIGH, 8'h80);
    #1 chk("irq", 8'h00, {7'h0, host_event_irq});
    rd(OFS_EVENT_HIGH, 8'h01);
  endtask
  task automatic guard_and_mask;
    wr(OFS_CLEAR_EN, 8'h7f);
    rd(OFS_CLEAR_EN, 8'h7f);
    raise(8'h80, 1'b1);
    wr(OFS_EVENT_HIGH, 8'h80);
    #1 chk("irq", 8'h01, {7'h0, host_event_irq});
    rd(OFS_EVENT_HIGH, 8'h81);
    wr(OFS_ENABLE_HIGH, 8'h00);
    #1 chk("irq", 8'h00, {7'h0, host_event_irq});
    wr(OFS_ENABLE_HIGH, 8'h01);
    #1 chk("irq", 8'h01, {7'h0, host_event_irq});
    wr(OFS_CLEAR_EN, 8'hff);
    wr(OFS_EVENT_HIGH, 8'hff);
    #1 chk("irq", 8'h00, {7'h0, host_event_irq});
    rd(OFS_EVENT_HIGH, 8'h00);
  endtask
  task automatic owner_claim;
    wr(OFS_OWNER_TAG, 8'h5a);
    rd(OFS_OWNER_TAG, 8'h5a);
    wr(OFS_OWNER_TAG, 8'h33);
    rd(OFS_OWNER_TAG, 8'h5a);
    wr(OFS_OWNER_TAG, 8'h5a);
    rd(OFS_OWNER_TAG, 8'h00);
  endtask
  task automatic allocate_all;
    // Lowest free tag first, until the pool runs dry
    for (int i = 1; i < 256; i++) begin
      rd(OFS_TAG_ALLOC, i[7:0]);
    end
    rd(OFS_TAG_ALLOC, NO_TAG);
  endtask
  task automatic free_and_reuse;
    wr(OFS_TAG_ALLOC, 8'h05);
    rd(OFS_TAG_ALLOC, 8'h05);
    wr(OFS_TAG_ALLOC, NO_TAG);
    rd(OFS_TAG_ALLOC, NO_TAG);
  endtask
  task automatic close_out;
    $display("mismatches %0d checked %0d", mismatches, checked);
    if (mismatches == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge ref_clk);
    reset_n <= 1;
    reset_values();
    mask_and_irq();
    guard_and_mask();
    owner_claim();
    allocate_all();
    free_and_reuse();
    close_out();
  end
endmodule
`default_nettype wire
